//--- verilog/loader_params.svh
// constants of the serial bootstrap command interpreter
`ifndef LOADER_PARAMS_SVH
`define LOADER_PARAMS_SVH
// register byte offsets
`define OFF_CMD 8'h00
`define OFF_ADDR 8'h04
`define OFF_DATA 8'h08
`define OFF_STATUS 8'h0C
`define OFF_RESULT 8'h10
`define OFF_HEX 8'h14
// status bit positions
`define ST_BUSY 0
`define ST_LOCK 1
`define ST_TRACE 2
`define ST_ERR 3
`define ST_MISM 4
`define ST_SEAL 5
`define ST_ECHO 6
// command characters
`define CH_CRC 8'h43
`define CH_DUMP 8'h44
`define CH_FILL 8'h46
`define CH_GET 8'h47
`define CH_LOAD 8'h4C
`define CH_SEAL 8'h4E
`define CH_PUT 8'h50
`define CH_READ 8'h52
`define CH_TRACE 8'h54
`define CH_UNLOCK 8'h55
`define CH_VERIFY 8'h56
`define CH_WRITE 8'h57
`define CH_LOCK 8'h5A
// sizes, counts and reset values
`define SRAM_LAST 8'h3F
`define VRAM_BYTES 16'h0030
`define KEY_LAST 8'h07
`define CRC_INIT 16'h0000
`define CRC_POLY 16'hA001
`define LFSR_SEED 16'hACE1
`define MEMORY_CONTROL_REG_RST 8'h00
`define RANGE_PARTITION_CONTROL_REG_RST 8'h00
`define RESP_OK 2'b00
`define RESP_ERR 2'b10
`endif

//--- verilog/loader_pkg.sv
// types of the serial bootstrap command interpreter
`default_nettype none
package loader_pkg;
  typedef enum logic [2:0] {
    S_ENTRY = 3'b000,
    S_IDLE = 3'b001,
    S_FILL = 3'b010,
    S_CRC = 3'b011,
    S_ERASE = 3'b100,
    S_REKEY = 3'b101
  } st_t;

  typedef struct packed {
    st_t st;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [31:0] data;
    logic [31:0] result;
    logic [63:0] key;
    logic [63:0] cand;
    logic [15:0] lfsr;
    logic [7:0] cnt;
    logic [15:0] crc;
    logic lock;
    logic seal;
    logic trace;
    logic err;
    logic mism;
    logic echo_v;
    logic [7:0] echo;
    logic [7:0] memory_control_reg;
    logic [7:0] range_partition_control_reg;
    logic memory_select_bit;
    logic [31:0] port_out;
    logic [63:0][7:0] sram;
    logic [47:0][7:0] vram;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;
endpackage : loader_pkg
`default_nettype wire

//--- verilog/secure_bootstrap_loader.sv
// bootstrap loader command interpreter with AXI4-Lite register access
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`include "loader_params.svh"
`default_nettype none
module secure_bootstrap_loader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [31:0] port_in,
  output logic [31:0] port_out
);
  loader_pkg::state_t s_reg;
  loader_pkg::state_t s_next;
  logic wr_go;
  logic rd_go;
  logic cmd_go;
  logic sram_cmd;
  logic [7:0] c;
  logic [7:0] sidx;
  logic [7:0] plain_b;
  logic [7:0] vram_b;
  logic [31:0] addr_m;

  ////////////////////////////////////////////////////////////////////////////
  // stand-in cipher: xor is its own inverse, so one function serves both ways
  function automatic logic [7:0] crypt(input logic [7:0] d, input logic [7:0] a, input logic [63:0] k);
    crypt = d ^ k[{a[2:0], 3'b000} +: 8] ^ a;
  endfunction : crypt

  function automatic logic [15:0] crc16(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] r;
    r = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    crc16 = r;
  endfunction : crc16

  function automatic logic [7:0] hexch(input logic [3:0] n);
    hexch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hexch

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFF_CMD) || (a == `OFF_ADDR) || (a == `OFF_DATA) ||
             (a == `OFF_STATUS) || (a == `OFF_RESULT) || (a == `OFF_HEX);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // one write and one read in flight; a held response blocks the next
  assign wr_go = awvalid && wvalid && !s_reg.bvalid;
  assign rd_go = arvalid && !s_reg.rvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign port_out = s_reg.port_out;
  assign c = wdata[7:0];
  assign cmd_go = wr_go && (awaddr == `OFF_CMD) && wstrb[0] && (s_reg.st == loader_pkg::S_IDLE);
  assign sram_cmd = (c == `CH_CRC) || (c == `CH_DUMP) || (c == `CH_FILL) ||
                    (c == `CH_LOAD) || (c == `CH_VERIFY);
  // cipher keyed by the SRAM index, so a load above the array still dumps back clear
  assign sidx = {2'b00, s_reg.addr[5:0]};
  assign plain_b = crypt(s_reg.sram[s_reg.addr[5:0]], sidx, s_reg.cand);
  assign vram_b = (s_reg.addr < `VRAM_BYTES) ? s_reg.vram[s_reg.addr[5:0]] : 8'h00;
  assign addr_m = merge({16'h0000, s_reg.addr}, wdata, wstrb);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.lfsr = {s_reg.lfsr[14:0], s_reg.lfsr[15] ^ s_reg.lfsr[13] ^ s_reg.lfsr[12] ^ s_reg.lfsr[10]};
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = mapped(araddr) ? `RESP_OK : `RESP_ERR;
      case (araddr)
        `OFF_CMD: s_next.rdata = {24'h0000_00, s_reg.cmd};
        `OFF_ADDR: s_next.rdata = {16'h0000, s_reg.addr};
        `OFF_DATA: s_next.rdata = s_reg.data;
        `OFF_STATUS: s_next.rdata = {25'h000_0000, s_reg.echo_v, s_reg.seal, s_reg.mism, s_reg.err,
                                     s_reg.trace, s_reg.lock, s_reg.st != loader_pkg::S_IDLE};
        `OFF_RESULT: s_next.rdata = s_reg.result;
        `OFF_HEX: begin
          s_next.rdata = {24'h0000_00, s_reg.echo};
          s_next.echo_v = 1'b0;
        end
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = mapped(awaddr) ? `RESP_OK : `RESP_ERR;
      case (awaddr)
        `OFF_ADDR: s_next.addr = addr_m[15:0];
        `OFF_DATA: s_next.data = merge(s_reg.data, wdata, wstrb);
        `OFF_STATUS: begin
          if (wstrb[0] && wdata[`ST_ERR]) s_next.err = 1'b0;
          if (wstrb[0] && wdata[`ST_MISM]) s_next.mism = 1'b0;
        end
        `OFF_HEX: begin
          if (s_reg.trace && wstrb[0]) begin
            s_next.echo = c;
            s_next.echo_v = 1'b1;
          end
        end
        `OFF_CMD: begin
          // commands arriving while busy are refused
          if (s_reg.st != loader_pkg::S_IDLE) s_next.bresp = `RESP_ERR;
        end
        default: ;
      endcase
    end
    case (s_reg.st)
      loader_pkg::S_ENTRY, loader_pkg::S_REKEY: begin
        if (s_reg.st == loader_pkg::S_ENTRY && s_reg.cnt == 8'h00) begin
          s_next.addr = 16'h0000;
          s_next.data = 32'h0000_0000;
          s_next.result = 32'h0000_0000;
          s_next.crc = `CRC_INIT;
        end
        s_next.cand = {s_reg.cand[55:0], s_reg.lfsr[7:0]};
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == `KEY_LAST) begin
          s_next.cnt = 8'h00;
          s_next.st = loader_pkg::S_IDLE;
          if (s_reg.st == loader_pkg::S_REKEY) s_next.key = {s_reg.cand[55:0], s_reg.lfsr[7:0]};
        end
      end
      loader_pkg::S_FILL: begin
        s_next.sram[s_reg.cnt[5:0]] = crypt(s_reg.data[7:0], s_reg.cnt, s_reg.key);
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == `SRAM_LAST) s_next.st = loader_pkg::S_IDLE;
      end
      loader_pkg::S_CRC: begin
        s_next.crc = crc16(s_reg.crc, crypt(s_reg.sram[s_reg.cnt[5:0]], s_reg.cnt, s_reg.key));
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == `SRAM_LAST) begin
          s_next.result = {16'h0000, s_next.crc};
          s_next.st = loader_pkg::S_IDLE;
        end
      end
      loader_pkg::S_ERASE: begin
        s_next.sram[s_reg.cnt[5:0]] = 8'h00;
        s_next.cnt = s_reg.cnt + 8'h01;
        if (s_reg.cnt == `SRAM_LAST) begin
          s_next.cnt = 8'h00;
          s_next.st = loader_pkg::S_REKEY;
        end
      end
      loader_pkg::S_IDLE: begin
        if (cmd_go) begin
          s_next.cmd = c;
          s_next.trace = 1'b0;
          if (sram_cmd && s_reg.lock) begin
            s_next.err = 1'b1;
          end else begin
            case (c)
              `CH_CRC: begin
                s_next.key = s_reg.cand;
                s_next.cnt = 8'h00;
                s_next.crc = `CRC_INIT;
                s_next.st = loader_pkg::S_CRC;
              end
              `CH_DUMP: begin
                s_next.key = s_reg.cand;
                if (s_reg.memory_select_bit) begin
                  s_next.result = {16'h0000, hexch(vram_b[7:4]), hexch(vram_b[3:0])};
                end else begin
                  s_next.result = {16'h0000, hexch(plain_b[7:4]), hexch(plain_b[3:0])};
                end
              end
              `CH_FILL: begin
                s_next.key = s_reg.cand;
                s_next.cnt = 8'h00;
                s_next.st = loader_pkg::S_FILL;
              end
              `CH_GET: s_next.result = port_in;
              `CH_LOAD: begin
                s_next.key = s_reg.cand;
                if (s_reg.addr < `VRAM_BYTES) s_next.vram[s_reg.addr[5:0]] = s_reg.data[7:0];
                else s_next.sram[s_reg.addr[5:0]] = crypt(s_reg.data[7:0], sidx, s_reg.cand);
              end
              `CH_SEAL: begin
                s_next.seal = 1'b1;
                s_next.sram = '0;
                s_next.vram = '0;
                s_next.key = 64'h0000_0000_0000_0000;
              end
              `CH_PUT: s_next.port_out = s_reg.data;
              `CH_READ: s_next.result = {8'h00, s_reg.memory_control_reg, s_reg.range_partition_control_reg, 7'h00, s_reg.memory_select_bit};
              `CH_TRACE: s_next.trace = 1'b1;
              `CH_UNLOCK: begin
                s_next.lock = 1'b0;
                s_next.key = 64'h0000_0000_0000_0000;
                s_next.vram = '0;
                s_next.cnt = 8'h00;
                s_next.st = loader_pkg::S_ERASE;
              end
              `CH_VERIFY: begin
                s_next.key = s_reg.cand;
                s_next.mism = s_reg.mism |
                  (plain_b != s_reg.data[7:0]);
              end
              `CH_WRITE: begin
                s_next.memory_control_reg = s_reg.data[23:16];
                s_next.range_partition_control_reg = s_reg.data[15:8];
                s_next.memory_select_bit = s_reg.data[0];
              end
              `CH_LOCK: s_next.lock = 1'b1;
              default: begin
                s_next.err = 1'b1;
                s_next.trace = s_reg.trace;
              end
            endcase
          end
        end
      end
      default: s_next.st = loader_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.lfsr <= `LFSR_SEED;
      s_reg.memory_control_reg <= `MEMORY_CONTROL_REG_RST;
      s_reg.range_partition_control_reg <= `RANGE_PARTITION_CONTROL_REG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence q_gather;
    (s_reg.st == loader_pkg::S_REKEY) [*8] ##1 (s_reg.st == loader_pkg::S_IDLE);
  endsequence

  property p_entry;
    (s_reg.st == loader_pkg::S_ENTRY && s_reg.cnt == 8'h00) |-> (s_reg.st == loader_pkg::S_ENTRY) [*8]
      ##1 (s_reg.st == loader_pkg::S_IDLE && s_reg.result == 32'h0000_0000);
  endproperty
  a_entry: assert property (p_entry) else $error("entry did not gather eight bytes");

  property p_lock_refuse;
    (cmd_go && sram_cmd && s_reg.lock) |=> (s_reg.err && s_reg.st == loader_pkg::S_IDLE && $stable(s_reg.sram));
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked SRAM command not refused");

  property p_key_copy;
    (cmd_go && sram_cmd && !s_reg.lock) |=> (s_reg.key == $past(s_reg.cand));
  endproperty
  a_key_copy: assert property (p_key_copy) else $error("key not loaded from candidate");

  property p_unlock;
    (cmd_go && c == `CH_UNLOCK) |=> (s_reg.key == 64'h0000_0000_0000_0000 && s_reg.vram == '0 && !s_reg.lock)
      ##64 q_gather;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock sequence out of order");

  property p_fill_len;
    (cmd_go && c == `CH_FILL && !s_reg.lock) |=> (s_reg.st == loader_pkg::S_FILL) ##63 ##1 (s_reg.st == loader_pkg::S_IDLE);
  endproperty
  a_fill_len: assert property (p_fill_len) else $error("fill did not take 64 cycles");

  property p_put;
    (cmd_go && c == `CH_PUT) |=> (port_out == $past(s_reg.data));
  endproperty
  a_put: assert property (p_put) else $error("put did not drive ports");

  property p_echo;
    (wr_go && awaddr == `OFF_HEX && wstrb[0] && s_reg.trace) |=> (s_reg.echo_v && s_reg.echo == $past(c));
  endproperty
  a_echo: assert property (p_echo) else $error("trace echo missing");

  property p_unknown;
    (cmd_go && c == 8'h41) |=> (s_reg.err && $stable(s_reg.key) && $stable(s_reg.lock) && $stable(port_out));
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command changed state");

  property p_locked_stays;
    (cmd_go && c == `CH_LOCK) |=> s_reg.lock [*2];
  endproperty
  a_locked_stays: assert property (p_locked_stays) else $error("lock not set");

  property p_cand_steady;
    (s_reg.st == loader_pkg::S_IDLE) |=> $stable(s_reg.cand);
  endproperty
  a_cand_steady: assert property (p_cand_steady) else $error("candidate key moved within a session");
endmodule : secure_bootstrap_loader
`default_nettype wire

//--- sim/io_port_model.sv
// partner model of the world on the four I/O ports
`default_nettype none
module io_port_model (
  input wire logic aclk,
  input wire logic [31:0] port_out,
  output logic [31:0] port_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // one cycle of pad lag, turned by a byte so a stuck loopback cannot pass
  always @(posedge aclk) begin
    port_in <= {port_out[7:0], port_out[31:8]};
  end
endmodule : io_port_model
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the bootstrap loader over its register bus
`include "loader_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, port_in, port_out, r;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int bad_count, n_checks;

  secure_bootstrap_loader secure_bootstrap_loader_i (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .port_in(port_in),
    .port_out(port_out)
  );
  io_port_model io_port_model_i (.aclk(aclk), .port_out(port_out), .port_in(port_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    r = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // bounded poll: a busy that never drops is reported, not hung on
  task automatic idle();
    for (int i = 0; i < 300; i++) begin
      rd(`OFF_STATUS);
      if (r[`ST_BUSY] === 1'b0) break;
    end
    chk({31'h0, r[`ST_BUSY]}, 32'h0000_0000);
  endtask : idle

  task automatic st(input int i, input logic e);
    rd(`OFF_STATUS);
    chk({31'h0, r[i]}, {31'h0, e});
  endtask : st

  task automatic op(input logic [7:0] ch, input logic [31:0] a, input logic [31:0] d);
    wr(`OFF_ADDR, a);
    wr(`OFF_DATA, d);
    wr(`OFF_CMD, {24'h0, ch});
    idle();
  endtask : op

  task automatic dump(input logic [31:0] a, input logic [15:0] e);
    op(`CH_DUMP, a, 32'h0000_0000);
    rd(`OFF_RESULT);
    chk({16'h0, r[15:0]}, {16'h0, e});
  endtask : dump

  // reflected crc over 64 equal bytes
  function automatic logic [15:0] crc_of(input logic [7:0] b);
    logic [15:0] c;
    c = `CRC_INIT;
    for (int n = 0; n < 64; n++) begin
      c = c ^ {8'h00, b};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_of

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    #800us;
    bad_count++;
    final_report();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    idle();
    op(`CH_UNLOCK, 0, 0);
    st(`ST_LOCK, 1'b0);
    rd(8'h20);
    chk({30'h0, resp}, {30'h0, `RESP_ERR});
    chk(r, 32'h0000_0000);
    wr(`OFF_CMD, 32'h0000_0041);
    st(`ST_ERR, 1'b1);
    wr(`OFF_STATUS, 32'h0000_0008);
    st(`ST_ERR, 1'b0);
    op(`CH_WRITE, 0, 32'h00ab_cd01);
    op(`CH_READ, 0, 0);
    rd(`OFF_RESULT);
    chk(r, 32'h00ab_cd01);
    op(`CH_WRITE, 0, 0);
    op(`CH_PUT, 0, 32'h1234_5678);
    chk(port_out, 32'h1234_5678);
    op(`CH_GET, 0, 0);
    rd(`OFF_RESULT);
    chk(r, 32'h7812_3456);
    wr(`OFF_DATA, 32'h0000_0033);
    wr(`OFF_CMD, {24'h0, `CH_FILL});
    wr(`OFF_CMD, {24'h0, `CH_GET});
    chk({30'h0, resp}, {30'h0, `RESP_ERR});
    idle();
    dump(5, 16'h3333);
    op(`CH_CRC, 0, 0);
    rd(`OFF_RESULT);
    chk(r, {16'h0, crc_of(8'h33)});
    op(`CH_VERIFY, 5, 32'h0000_0033);
    st(`ST_MISM, 1'b0);
    op(`CH_VERIFY, 5, 32'h0000_0034);
    st(`ST_MISM, 1'b1);
    op(`CH_LOAD, 16, 32'h0000_0077);
    op(`CH_WRITE, 0, 1);
    dump(16, 16'h3737);
    op(`CH_WRITE, 0, 0);
    dump(16, 16'h3333);
    op(`CH_LOAD, 32'h40, 32'h0000_0011);
    dump(0, 16'h3131);
    op(`CH_TRACE, 0, 0);
    wr(`OFF_HEX, 32'h0000_003a);
    st(`ST_ECHO, 1'b1);
    rd(`OFF_HEX);
    chk({24'h0, r[7:0]}, 32'h0000_003a);
    op(`CH_LOCK, 0, 0);
    st(`ST_LOCK, 1'b1);
    op(`CH_DUMP, 0, 0);
    st(`ST_ERR, 1'b1);
    op(`CH_UNLOCK, 0, 0);
    st(`ST_LOCK, 1'b0);
    op(`CH_WRITE, 0, 1);
    dump(16, 16'h3030);
    op(`CH_LOAD, 8, 32'h0000_005a);
    dump(8, 16'h3541);
    op(`CH_SEAL, 0, 0);
    st(`ST_SEAL, 1'b1);
    dump(8, 16'h3030);
    final_report();
  end
endmodule : testbench
`default_nettype wire
